/* hw/dsw_builder.sv */
// Drive status word and actual frequency word builder
// Overview of operation
// - Bit 00 set when control ready, not tripped
// - Bit 01 ready but coasting commanded
// - Bit 02 clear while coasting, else set
// - Bit 03 set while tripped until reset
// - Bit 04 set on error without trip
// - Bit 05 always zero
// - Bit 06 set while trip-locked
// - Bit 07 set when any warning present
// - Bit 08 set when speed equals reference
// - Bit 09 set unless local stop/reference active
// - Bit 10 set inside frequency limits
// - Bit 11 set on start or frequency not zero
// - Bit 12 set during thermal auto-stop
// - Bit 13 set on DC voltage fault
// - Bit 14 set when current exceeds limit
// - Bit 15 set when thermal timer exceeds full
// - Whole word zero when link lost
// - Reference 16384 means full scale
// - Negative values use two's complement
// - Frequency word scaled like reference
// - Warnings follow cause, no reset needed
// - Trip held until reset and cause cleared
// - Command reset acts on rising edge only
`timescale 1ns/1ps
`default_nettype none
module dsw_builder #(
   parameter int unsigned WORD_W = dsw_pkg::WORD_W  // Word width
) (
   input  wire logic                clk,                // 250 MHz drive clock
   input  wire logic                resetn,             // Asynchronous reset, active low
   input  wire dsw_pkg::dsw_core_t  core,               // Drive core conditions
   input  wire dsw_pkg::dsw_fault_t fault,              // Alarm sources
   input  wire logic                power_cycle,        // Mains restored pulse
   input  wire logic                panel_reset,        // Local operator panel reset pulse
   input  wire logic                input_reset,        // Digital input reset pulse
   input  wire logic                auto_reset,         // Automatic reset pulse
   input  wire logic [WORD_W-1:0]   drive_command_word, // Command word from master
   input  wire logic                cmd_valid,          // Command word present
   input  wire logic [WORD_W-1:0]   speed_ref_word,     // Relative speed reference
   output logic [WORD_W-1:0]        drive_status_word,  // Status word to master
   output logic [WORD_W-1:0]        actual_frequency_word, // Actual frequency word
   output logic signed [WORD_W:0]   speed_ref_pct_q14,  // Reference, 16384 = 100 %
   output logic                     tripped,            // Drive tripped
   output logic                     trip_locked         // Drive trip-locked
);
   // ------------------------------------------------------------
   // Reset synchroniser
   // ------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // Reset requests and trip state
   // ------------------------------------------------------------
   logic cmd_reset_level;
   logic cmd_reset_rise;
   logic any_reset;

   assign cmd_reset_level = cmd_valid & drive_command_word[dsw_pkg::CMD_BIT_RESET];

   dsw_edge_detect u_reset_edge (
      .clk      (clk),
      .rst_n    (rst_n_reg),
      .level_in (cmd_reset_level),
      .rise     (cmd_reset_rise)
   );

   assign any_reset = cmd_reset_rise | panel_reset | input_reset | auto_reset;

   dsw_trip_keeper u_trip (
      .clk         (clk),
      .rst_n       (rst_n_reg),
      .fault       (fault),
      .reset_req   (any_reset),
      .power_cycle (power_cycle),
      .tripped     (tripped),
      .locked      (trip_locked)
   );

   // ------------------------------------------------------------
   // Status conditions
   // ------------------------------------------------------------
   logic              volt_warn;
   logic              timer_exc;
   logic              warn_any;
   logic              freq_nonzero;
   logic [WORD_W-1:0] status_next;

   assign volt_warn = core.dc_volt_low | core.dc_volt_high;
   assign timer_exc = ($signed(core.motor_timer) > $signed(dsw_pkg::TIMER_FULL))
                    | ($signed(core.inverter_timer) > $signed(dsw_pkg::TIMER_FULL));
   // Warnings are pure levels of their causes
   assign warn_any  = volt_warn | core.current_over_limit | timer_exc
                    | core.temp_stop;
   assign freq_nonzero = (core.out_freq_rel != '0);

   always_comb begin
      status_next = dsw_pkg::STATUS_RESET;
      status_next[dsw_pkg::BIT_CTRL_READY]  = core.ctrl_ready & ~tripped;
      status_next[dsw_pkg::BIT_DRV_READY]   = core.ctrl_ready & ~tripped
                                              & core.coast_cmd;
      status_next[dsw_pkg::BIT_ENABLE]      = ~core.coast_cmd;
      status_next[dsw_pkg::BIT_TRIP]        = tripped;
      status_next[dsw_pkg::BIT_ERROR]       = core.error_no_trip;
      status_next[dsw_pkg::BIT_RESERVED]    = 1'b0;
      status_next[dsw_pkg::BIT_TRIPLOCK]    = trip_locked;
      status_next[dsw_pkg::BIT_WARNING]     = warn_any;
      status_next[dsw_pkg::BIT_SPEED_MATCH] = core.speed_at_ref;
      status_next[dsw_pkg::BIT_BUS_CTRL]    = ~(core.local_stop_active
                                                | core.local_ref_sel);
      status_next[dsw_pkg::BIT_FREQ_OK]     = ~(core.at_low_limit
                                                | core.at_high_limit);
      status_next[dsw_pkg::BIT_RUNNING]     = core.start_cmd | freq_nonzero;
      status_next[dsw_pkg::BIT_AUTO_STOP]   = core.temp_stop;
      status_next[dsw_pkg::BIT_VOLT_EXC]    = volt_warn;
      status_next[dsw_pkg::BIT_TORQUE_EXC]  = core.current_over_limit;
      status_next[dsw_pkg::BIT_TIMER_EXC]   = timer_exc;
      if (!core.link_ok) begin
         status_next = '0;
      end
   end

   // ------------------------------------------------------------
   // Snapshot registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         drive_status_word     <= dsw_pkg::STATUS_RESET;
         actual_frequency_word <= dsw_pkg::FREQ_RESET;
      end else begin
         drive_status_word     <= status_next;
         // Same relative two's-complement scaling as the reference
         actual_frequency_word <= core.out_freq_rel;
      end
   end

   // ------------------------------------------------------------
   // Speed reference decode
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         speed_ref_pct_q14 <= '0;
      end else if (cmd_valid) begin
         // Sign extended, 16384 stands for exactly 100 %
         speed_ref_pct_q14 <= {speed_ref_word[WORD_W-1], speed_ref_word};
      end
   end
endmodule : dsw_builder
`default_nettype wire

/* pkg/dsw_pkg.sv */
// Package: status word bit positions, scaling constants and carrier structs
package dsw_pkg;

   // Status word bit positions
   localparam int unsigned BIT_CTRL_READY  = 0;
   localparam int unsigned BIT_DRV_READY   = 1;
   localparam int unsigned BIT_ENABLE      = 2;
   localparam int unsigned BIT_TRIP        = 3;
   localparam int unsigned BIT_ERROR       = 4;
   localparam int unsigned BIT_RESERVED    = 5;
   localparam int unsigned BIT_TRIPLOCK    = 6;
   localparam int unsigned BIT_WARNING     = 7;
   localparam int unsigned BIT_SPEED_MATCH = 8;
   localparam int unsigned BIT_BUS_CTRL    = 9;
   localparam int unsigned BIT_FREQ_OK     = 10;
   localparam int unsigned BIT_RUNNING     = 11;
   localparam int unsigned BIT_AUTO_STOP   = 12;
   localparam int unsigned BIT_VOLT_EXC    = 13;
   localparam int unsigned BIT_TORQUE_EXC  = 14;
   localparam int unsigned BIT_TIMER_EXC   = 15;

   // Command word reset bit
   localparam int unsigned CMD_BIT_RESET   = 7;

   // Word widths and scaling
   localparam int unsigned WORD_W          = 16;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;
   localparam logic [15:0] FULL_SCALE_REF  = 16'h4000;
   localparam logic [15:0] FREQ_RESET      = 16'h0000;
   // Thermal timers: 100 % of full scale on a 16-bit percentage count
   localparam logic [15:0] TIMER_FULL      = 16'h4000;

   // Drive core conditions sampled each cycle
   typedef struct packed {
      logic        ctrl_ready;
      logic        coast_cmd;
      logic        start_cmd;
      logic        error_no_trip;
      logic        speed_at_ref;
      logic        local_stop_active;
      logic        local_ref_sel;
      logic        at_low_limit;
      logic        at_high_limit;
      logic        temp_stop;
      logic        dc_volt_low;
      logic        dc_volt_high;
      logic        current_over_limit;
      logic [15:0] motor_timer;
      logic [15:0] inverter_timer;
      logic [15:0] out_freq_rel;
      logic        link_ok;
   } dsw_core_t;

   // Fault sources towards the trip keeper
   typedef struct packed {
      logic alarm;
      logic alarm_lock;
      logic cause_active;
   } dsw_fault_t;

endpackage : dsw_pkg

/* hw/dsw_edge_detect.sv */
// Rising-edge detector for the command-word reset bit
`timescale 1ns/1ps
`default_nettype none
module dsw_edge_detect (
   input  wire logic clk,      // Drive clock
   input  wire logic rst_n,    // Synchronised reset, active low
   input  wire logic level_in, // Level to watch
   output logic      rise      // One-cycle pulse on 0 to 1
);
   logic prev_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_reg <= 1'b1;
      end else begin
         prev_reg <= level_in;
      end
   end

   // Starts high so a level already held at reset does not fire
   assign rise = level_in & ~prev_reg;
endmodule : dsw_edge_detect
`default_nettype wire

/* hw/dsw_trip_keeper.sv */
// Trip and trip-lock state keeper
`timescale 1ns/1ps
`default_nettype none
module dsw_trip_keeper (
   input  wire logic              clk,        // Drive clock
   input  wire logic              rst_n,      // Synchronised reset, active low
   input  wire dsw_pkg::dsw_fault_t fault,    // Alarm sources
   input  wire logic              reset_req,  // Any reset pulse
   input  wire logic              power_cycle,// Mains restored, unlocks a lock
   output logic                   tripped,    // Tripped state
   output logic                   locked      // Trip-locked state
);
   typedef enum logic [1:0] {ST_OK, ST_TRIP, ST_LOCK} dsw_trip_state_t;
   dsw_trip_state_t state_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_OK;
      end else begin
         case (state_reg)
            ST_OK: begin
               if (fault.alarm_lock) begin
                  state_reg <= ST_LOCK;
               end else if (fault.alarm) begin
                  state_reg <= ST_TRIP;
               end
            end
            ST_TRIP: begin
               if (fault.alarm_lock) begin
                  state_reg <= ST_LOCK;
               end else if (reset_req && !fault.cause_active && !fault.alarm) begin
                  // An alarm in the same cycle wins over the reset
                  state_reg <= ST_OK;
               end
            end
            ST_LOCK: begin
               if (power_cycle) begin
                  state_reg <= ST_TRIP;
               end
            end
            default: begin
               state_reg <= ST_OK;
            end
         endcase
      end
   end

   assign tripped = (state_reg != ST_OK);
   assign locked  = (state_reg == ST_LOCK);
endmodule : dsw_trip_keeper
`default_nettype wire

/* verif/dsw_builder_checker.sv */
// Checker: status word assertions, bound to the builder
`timescale 1ns/1ps
`default_nettype none
module dsw_builder_checker #(
   parameter int unsigned WORD_W = 16 // Word width
) (
   input wire logic                clk,                   // Clock
   input wire logic                resetn,                // Reset, active low
   input wire dsw_pkg::dsw_core_t  core,                  // Core conditions
   input wire dsw_pkg::dsw_fault_t fault,                 // Alarm sources
   input wire logic                cmd_valid,             // Words present
   input wire logic [WORD_W-1:0]   speed_ref_word,        // Reference in
   input wire logic [WORD_W-1:0]   drive_status_word,     // Status out
   input wire logic [WORD_W-1:0]   actual_frequency_word, // Frequency out
   input wire logic signed [WORD_W:0] speed_ref_pct_q14,  // Reference out
   input wire logic                tripped,               // Tripped
   input wire logic                trip_locked            // Trip-locked
);
   // Skip the cycles in which the synchronised reset still holds
   logic [2:0] up_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) up_reg <= 3'h0;
      else if (up_reg != 3'h5) up_reg <= up_reg + 3'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn || up_reg != 3'h5);
   chk_spare_bit: assert property (drive_status_word[5] == 1'b0)
      else $error("spare bit set");
   chk_link_zero: assert property (!$past(core.link_ok) |-> drive_status_word == '0)
      else $error("word not zero on link loss");
   chk_trip_bit: assert property ($past(core.link_ok) |-> drive_status_word[3] == $past(tripped))
      else $error("trip bit wrong");
   chk_lock_bit: assert property ($past(core.link_ok) |-> drive_status_word[6] == $past(trip_locked))
      else $error("lock bit wrong");
   chk_freq_copy: assert property (actual_frequency_word == $past(core.out_freq_rel))
      else $error("frequency word wrong");
   chk_alarm_trip: assert property (fault.alarm |=> tripped)
      else $error("alarm did not trip");
   chk_trip_hold: assert property (tripped && fault.cause_active && !fault.alarm |=> tripped)
      else $error("trip left with cause present");
   chk_ref_scale: assert property (cmd_valid |=> speed_ref_pct_q14 ==
      {$past(speed_ref_word[WORD_W-1]), $past(speed_ref_word)})
      else $error("reference not sign extended");
   cover property (tripped ##1 !tripped);
   cover property (!core.link_ok);
   cover property (cmd_valid && speed_ref_word[WORD_W-1]);
   cover property (trip_locked ##1 !trip_locked);
endmodule : dsw_builder_checker
bind dsw_builder dsw_builder_checker #(.WORD_W(WORD_W)) i_dsw_builder_checker (
   .clk(clk), .resetn(resetn), .core(core), .fault(fault), .cmd_valid(cmd_valid),
   .speed_ref_word(speed_ref_word), .drive_status_word(drive_status_word),
   .actual_frequency_word(actual_frequency_word), .speed_ref_pct_q14(speed_ref_pct_q14),
   .tripped(tripped), .trip_locked(trip_locked));
`default_nettype wire

/* verif/dsw_master_model.sv */
// Master model: command word and speed reference source
`timescale 1ns/1ps
`default_nettype none
module dsw_master_model (
   output var logic [15:0] drive_command_word, // Command word
   output var logic        cmd_valid,          // Words present
   output var logic [15:0] speed_ref_word      // Relative reference
);
   initial begin
      drive_command_word = 16'h0000;
      cmd_valid = 1'b0;
      speed_ref_word = 16'h0000;
   end
   // Called just after an edge; a reset is a fresh 0 to 1 of bit 7
   task automatic put(input logic [15:0] cmd, input logic [15:0] pct);
      drive_command_word <= cmd;
      cmd_valid <= 1'b1;
      speed_ref_word <= pct;
   endtask : put
endmodule : dsw_master_model
`default_nettype wire

/* verif/tb_top.sv */
// Testbench: drives the status word builder and scores its outputs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {
      int          due;
      logic [15:0] sw;
      logic [15:0] fw;
      logic [16:0] rf;
      logic        tr;
      logic        tl;
   } dsw_note_t;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic power_cycle = 1'b0;
   logic panel_reset = 1'b0;
   logic input_reset = 1'b0;
   logic auto_reset = 1'b0;
   dsw_pkg::dsw_core_t  core = '0;
   dsw_pkg::dsw_fault_t fault = '0;
   wire logic [15:0] cmd_w;
   wire logic [15:0] ref_w;
   wire logic        cmd_v;
   logic [15:0] sw;
   logic [15:0] fw;
   logic [16:0] rf;
   logic        tr;
   logic        tl;
   dsw_note_t   notes[$];
   dsw_note_t   got;
   logic [15:0] bnd[4] = '{16'h4000, 16'h4001, 16'h0000, 16'hc000};
   int   cyc = 0;
   int   seed = 39768;
   int   miscompares = 0;
   int   total_checks = 0;
   logic m_trip = 1'b0;
   logic prev_b7 = 1'b0;
   logic m_lock = 1'b0;
   logic pc_req = 1'b0;
   always #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   dsw_master_model i_dsw_master_model (.drive_command_word(cmd_w), .cmd_valid(cmd_v),
      .speed_ref_word(ref_w));
   dsw_builder i_dsw_builder (.clk(clk), .resetn(resetn), .core(core), .fault(fault),
      .power_cycle(power_cycle), .panel_reset(panel_reset), .input_reset(input_reset),
      .auto_reset(auto_reset), .drive_command_word(cmd_w), .cmd_valid(cmd_v),
      .speed_ref_word(ref_w), .drive_status_word(sw), .actual_frequency_word(fw),
      .speed_ref_pct_q14(rf), .tripped(tr), .trip_locked(tl));
   function automatic logic [15:0] word(dsw_pkg::dsw_core_t c, logic t, logic l);
      logic [15:0] w;
      w = 16'h0000;
      w[0] = c.ctrl_ready & ~t;
      w[1] = c.ctrl_ready & ~t & c.coast_cmd;
      w[2] = ~c.coast_cmd;
      w[3] = t;
      w[4] = c.error_no_trip;
      w[6] = l;
      w[8] = c.speed_at_ref;
      w[9] = ~(c.local_stop_active | c.local_ref_sel);
      w[10] = ~(c.at_low_limit | c.at_high_limit);
      w[11] = c.start_cmd | (c.out_freq_rel != 16'h0000);
      w[12] = c.temp_stop;
      w[13] = c.dc_volt_low | c.dc_volt_high;
      w[14] = c.current_over_limit;
      w[15] = ($signed(c.motor_timer) > $signed(dsw_pkg::TIMER_FULL)) |
              ($signed(c.inverter_timer) > $signed(dsw_pkg::TIMER_FULL));
      w[7] = w[12] | w[13] | w[14] | w[15];
      return c.link_ok ? w : 16'h0000;
   endfunction : word
   task automatic apply(dsw_pkg::dsw_core_t c, dsw_pkg::dsw_fault_t f, logic [2:0] rs,
                        logic [15:0] cmd, logic [15:0] pct);
      dsw_note_t n;
      logic      e;
      @(posedge clk);
      core <= c;
      fault <= f;
      {auto_reset, input_reset, panel_reset} <= rs;
      power_cycle <= pc_req;
      i_dsw_master_model.put(cmd, pct);
      e = cmd[7] & ~prev_b7;
      prev_b7 = cmd[7];
      n.due = cyc + 2;
      n.sw = word(c, m_trip, m_lock);
      n.fw = c.out_freq_rel;
      n.rf = {pct[15], pct};
      if (f.alarm | f.alarm_lock) m_trip = 1'b1;
      else if ((e | (|rs)) & ~f.cause_active & ~m_lock) m_trip = 1'b0;
      if (m_lock & pc_req) m_lock = 1'b0;
      else if (f.alarm_lock) m_lock = 1'b1;
      n.tr = m_trip;
      n.tl = m_lock;
      notes.push_back(n);
   endtask : apply
   task automatic check(string what, logic [16:0] seen, logic [16:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   always @(negedge clk) begin
      if (notes.size() > 0 && notes[0].due == cyc) begin
         got = notes.pop_front();
         check("status", {1'b0, sw}, {1'b0, got.sw});
         check("frequency", {1'b0, fw}, {1'b0, got.fw});
         check("reference", rf, got.rf);
         check("tripped", {16'h0000, tr}, {16'h0000, got.tr});
         check("locked", {16'h0000, tl}, {16'h0000, got.tl});
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize
   initial begin
      #20000;
      miscompares++;
      summarize();
   end
   initial begin
      dsw_pkg::dsw_core_t c;
      logic [63:0]        r;
      logic [2:0]         rs;
      logic [15:0]        cw;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      repeat (300) begin
         r = {$random(seed), $random(seed)};
         c = r[61:0];
         apply(c, '0, 3'h0, 16'h0000, r[63:48]);
      end
      $display("random test done");
      c = '0;
      c.ctrl_ready = 1'b1;
      c.link_ok = 1'b1;
      foreach (bnd[i]) begin
         c.motor_timer = bnd[i];
         c.inverter_timer = bnd[3-i];
         c.out_freq_rel = bnd[i];
         apply(c, '0, 3'h0, 16'h0000, bnd[i]);
      end
      $display("boundary test done");
      for (int s = 0; s < 4; s++) begin
         rs = (s < 3) ? 3'h1 << s : 3'h0;
         cw = (s == 3) ? 16'h0080 : 16'h0000;
         apply(c, 3'h5, 3'h0, 16'h0000, 16'h0000);
         apply(c, 3'h1, rs, cw, 16'h0000);
         apply(c, 3'h0, 3'h0, 16'h0000, 16'h0000);
         apply(c, 3'h0, rs, cw, 16'h0000);
         apply(c, 3'h0, 3'h0, cw, 16'h0000);
      end
      apply(c, 3'h4, 3'h0, 16'h0080, 16'h0000);
      apply(c, 3'h0, 3'h0, 16'h0080, 16'h0000);
      apply(c, 3'h0, 3'h0, 16'h0000, 16'h0000);
      apply(c, 3'h0, 3'h0, 16'h0080, 16'h0000);
      repeat (4) @(posedge clk);
      $display("trip test done");
      apply(c, 3'h2, 3'h0, 16'h0000, 16'h0000);
      apply(c, 3'h0, 3'h1, 16'h0080, 16'h0000);
      pc_req = 1'b1;
      apply(c, 3'h0, 3'h0, 16'h0000, 16'h0000);
      pc_req = 1'b0;
      apply(c, 3'h4, 3'h2, 16'h0000, 16'h0000);
      apply(c, 3'h0, 3'h2, 16'h0000, 16'h0000);
      repeat (4) @(posedge clk);
      $display("lock test done");
      summarize();
   end
endmodule : tb_top
`default_nettype wire
